/* stepper_bus_pkg.sv */
package stepper_bus_pkg;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned BAUD_RATE       = 2_400;
   localparam int unsigned BIT_CYCLES      = (CLK_HZ + BAUD_RATE / 2) / BAUD_RATE;
   localparam int unsigned REF_WAIT_MS     = 2_400;
   localparam int unsigned REF_WAIT_CYCLES = (CLK_HZ / 1_000) * REF_WAIT_MS;

   // ****************************************************************
   // framing
   // ****************************************************************
   localparam logic [4:0] FRAME_LAST      = 5'h15;   // 2 x (start, 8 data, parity, stop)
   localparam logic [3:0] PAUSE_BITS      = 4'hc;    // longer than one byte time
   localparam logic [3:0] SYNC_REPEAT_MIN = 4'h4;
   localparam logic [3:0] FIRST_REF_COUNT = 4'h3;
   localparam logic [3:0] SINGLE_FRAME    = 4'h1;
   localparam logic       LEVEL_START     = 1'b0;
   localparam logic       LEVEL_STOP      = 1'b1;

   // ****************************************************************
   // command fields
   // ****************************************************************
   localparam logic [3:0] ID_EXTEND    = 4'h9;
   localparam logic [3:0] ID_RETRACT   = 4'h6;
   localparam logic [1:0] MODE_NORMAL  = 2'h0;
   localparam logic [1:0] MODE_TEST    = 2'h3;
   localparam logic [7:0] SYNC_BYTE    = 8'haa;
   localparam logic [7:0] REF_LOW_BYTE = 8'h00;
   localparam logic [9:0] MAX_POSITION = 10'h2ba;   // 698, reference run length

   typedef enum logic [1:0] {
      CMD_SYNC,
      CMD_REF,
      CMD_POS
   } cmd_kind_e;

   typedef struct packed {
      cmd_kind_e  kind;
      logic       retract;     // 0: zero = full extension, 1: zero = full retraction
      logic       test_mode;   // reduced coil current
      logic [9:0] position;
   } cmd_s;

   typedef struct packed {
      logic synced;
      logic referenced;
      logic holding;
      logic fault;
   } link_status_s;

endpackage

/* stepper_bus_controller.sv */
`timescale 1ns/10ps
// Function
// - controller pulls the bus low to send data and clock at about 2400 baud
// - synchronisation pattern is sent at least four times
// - an idle-high pause separates consecutive commands
// - sixteen-bit command as two bytes, upper byte first, lower immediately after
// - each byte framed by start bit, data, parity bit, stop bit
// - parity is odd over data bits plus parity bit
// - upper byte: identifier in bits 3..0, mode 5..4, position data 7..6
// - reference run: mode 00, zero lower byte, identifier 1001 or 0110
// - ten-bit target: upper 7 = bit 8, upper 6 = bit 9, lower reversed
// - controller never commands a target above 698
// - commands ignored during a reference run; wait about 2.4 s after one
module stepper_bus_controller
   import stepper_bus_pkg::*;
#(
   parameter int unsigned BIT_TICKS   = BIT_CYCLES,
   parameter int unsigned REF_TICKS   = REF_WAIT_CYCLES,
   parameter logic [3:0]  SYNC_FRAMES = SYNC_REPEAT_MIN
) (
   input  wire logic         clock,
   input  wire logic         rst_b,
   input  wire logic         cmd_valid,
   input  wire cmd_s         cmd,
   output logic              cmd_ready,
   output logic              cmd_done,
   output logic              cmd_refused,
   input  wire logic         fault_clr,
   output link_status_s      status,
   input  wire logic         bus_in,
   output logic              bus_out,
   output logic              bus_oe
);

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SEND,
      ST_PAUSE,
      ST_HOLD
   } state_e;

   state_e       st_ff;
   state_e       nxt_st;
   cmd_s         cmd_ff;
   logic [21:0]  frame_ff;
   logic [4:0]   bit_idx_ff;
   logic [3:0]   pause_cnt_ff;
   logic [3:0]   frames_left_ff;
   logic [3:0]   frames_sent_ff;
   logic [31:0]  div_ff;
   logic [31:0]  wait_ff;
   logic [31:0]  low_cnt_ff;
   logic         bus_in_meta_ff;
   logic         bus_in_ff;
   logic         bus_oe_ff;
   logic         synced_ff;
   logic         referenced_ff;
   logic         locked_retract_ff;
   logic         fault_ff;
   logic         cmd_ready_ff;
   logic         cmd_done_ff;
   logic         cmd_refused_ff;
   logic         holding_ff;

   logic         bit_tick;
   logic         accept;
   logic         refuse;
   logic         go;
   logic         load;
   logic         frame_end;
   logic         pause_end;
   logic         finish;
   logic [3:0]   nxt_frames;
   logic [7:0]   hi_byte;
   logic [7:0]   lo_byte;
   logic [7:0]   pos_rev;
   logic [21:0]  frame_word;
   cmd_s         src_cmd;

   // ****************************************************************
   // bus input synchroniser
   // ****************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bus_in_meta_ff <= 1'b1;
         bus_in_ff      <= 1'b1;
      end else begin
         bus_in_meta_ff <= bus_in;
         bus_in_ff      <= bus_in_meta_ff;
      end
   end

   // ****************************************************************
   // command encoding
   // ****************************************************************
   // the accepting edge loads the frame before cmd_ff holds the request
   assign src_cmd = go ? cmd : cmd_ff;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_rev
         assign pos_rev[7 - gi] = src_cmd.position[gi];
      end
   endgenerate

   always_comb begin
      hi_byte = SYNC_BYTE;
      lo_byte = SYNC_BYTE;
      case (src_cmd.kind)
         CMD_REF: begin
            hi_byte = {2'h0, MODE_NORMAL, src_cmd.retract ? ID_RETRACT : ID_EXTEND};
            lo_byte = REF_LOW_BYTE;
         end
         CMD_POS: begin
            hi_byte = {src_cmd.position[8], src_cmd.position[9],
                       src_cmd.test_mode ? MODE_TEST : MODE_NORMAL,
                       src_cmd.retract ? ID_RETRACT : ID_EXTEND};
            lo_byte = pos_rev;
         end
         default: begin
            hi_byte = SYNC_BYTE;
            lo_byte = SYNC_BYTE;
         end
      endcase
   end

   // sent lsb first: upper byte occupies the first eleven bit slots
   assign frame_word = {LEVEL_STOP, ~^lo_byte, lo_byte, LEVEL_START,
                        LEVEL_STOP, ~^hi_byte, hi_byte, LEVEL_START};

   // ****************************************************************
   // command acceptance
   // ****************************************************************
   assign accept = cmd_valid && cmd_ready_ff && (st_ff == ST_IDLE);

   always_comb begin
      refuse     = 1'b0;
      nxt_frames = SINGLE_FRAME;
      case (cmd.kind)
         CMD_SYNC: begin
            nxt_frames = SYNC_FRAMES;
         end
         CMD_REF: begin
            refuse     = !synced_ff || (referenced_ff && (cmd.retract != locked_retract_ff));
            nxt_frames = referenced_ff ? SINGLE_FRAME : FIRST_REF_COUNT;
         end
         CMD_POS: begin
            refuse = !synced_ff || !referenced_ff
                     || (cmd.retract != locked_retract_ff)
                     || (cmd.position > MAX_POSITION);
         end
         default: begin
            refuse = 1'b1;
         end
      endcase
   end

   assign go        = accept && !refuse;
   assign bit_tick  = (div_ff == BIT_TICKS - 1);
   assign frame_end = (st_ff == ST_SEND) && bit_tick && (bit_idx_ff == FRAME_LAST);
   assign pause_end = (st_ff == ST_PAUSE) && bit_tick && (pause_cnt_ff == PAUSE_BITS - 4'h1);
   assign finish    = pause_end && (frames_left_ff == SINGLE_FRAME);
   assign load      = pause_end && (frames_left_ff != SINGLE_FRAME);

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE:  if (go) nxt_st = ST_SEND;
         ST_SEND:  if (frame_end) nxt_st = ST_PAUSE;
         ST_PAUSE: begin
            if (load) begin
               nxt_st = ST_SEND;
            end else if (finish) begin
               nxt_st = (cmd_ff.kind == CMD_REF) ? ST_HOLD : ST_IDLE;
            end
         end
         ST_HOLD:  if (wait_ff == REF_TICKS - 1) nxt_st = ST_IDLE;
         default:  nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) st_ff <= ST_IDLE;
      else        st_ff <= nxt_st;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cmd_ff         <= '0;
         frames_left_ff <= SINGLE_FRAME;
         frames_sent_ff <= 4'h0;
      end else if (go) begin
         cmd_ff         <= cmd;
         frames_left_ff <= nxt_frames;
         frames_sent_ff <= 4'h0;
      end else begin
         if (load) frames_left_ff <= frames_left_ff - 4'h1;
         if (frame_end) frames_sent_ff <= frames_sent_ff + 4'h1;
      end
   end

   // bit divider restarts with every frame; only runs while the link is busy
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) div_ff <= 32'h0;
      else if (go || (st_ff == ST_IDLE) || (st_ff == ST_HOLD) || bit_tick) div_ff <= 32'h0;
      else div_ff <= div_ff + 32'h1;
   end

   // ****************************************************************
   // serialiser and pause
   // ****************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         frame_ff   <= '1;
         bit_idx_ff <= 5'h0;
         bus_oe_ff  <= 1'b0;
      end else if (go || load) begin
         frame_ff   <= frame_word;
         bit_idx_ff <= 5'h0;
         bus_oe_ff  <= 1'b1;
      end else if (frame_end) begin
         bus_oe_ff  <= 1'b0;
      end else if ((st_ff == ST_SEND) && bit_tick) begin
         frame_ff   <= {1'b1, frame_ff[21:1]};
         bit_idx_ff <= bit_idx_ff + 5'h1;
         bus_oe_ff  <= ~frame_ff[1];
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) pause_cnt_ff <= 4'h0;
      else if (st_ff != ST_PAUSE) pause_cnt_ff <= 4'h0;
      else if (bit_tick) pause_cnt_ff <= pause_cnt_ff + 4'h1;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) wait_ff <= 32'h0;
      else if (st_ff != ST_HOLD) wait_ff <= 32'h0;
      else wait_ff <= wait_ff + 32'h1;
   end

   // ****************************************************************
   // link state
   // ****************************************************************
   // referencing is assumed complete once the last repeat has gone out
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         synced_ff         <= 1'b0;
         referenced_ff     <= 1'b0;
         locked_retract_ff <= 1'b0;
      end else if (finish) begin
         if (cmd_ff.kind == CMD_SYNC) synced_ff <= 1'b1;
         if ((cmd_ff.kind == CMD_REF) && !referenced_ff) begin
            referenced_ff     <= 1'b1;
            locked_retract_ff <= cmd_ff.retract;
         end
      end
   end

   // a line held low while released means the device is clamping it
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) low_cnt_ff <= 32'h0;
      else if (bus_oe_ff || bus_in_ff) low_cnt_ff <= 32'h0;
      else if (low_cnt_ff != BIT_TICKS - 1) low_cnt_ff <= low_cnt_ff + 32'h1;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) fault_ff <= 1'b0;
      else if (low_cnt_ff == BIT_TICKS - 1) fault_ff <= 1'b1;
      else if (fault_clr) fault_ff <= 1'b0;
   end

   // ****************************************************************
   // user handshake
   // ****************************************************************
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         cmd_ready_ff   <= 1'b0;
         cmd_done_ff    <= 1'b0;
         cmd_refused_ff <= 1'b0;
         holding_ff     <= 1'b0;
      end else begin
         cmd_ready_ff   <= (nxt_st == ST_IDLE);
         holding_ff     <= (nxt_st == ST_HOLD);
         cmd_done_ff    <= finish;
         cmd_refused_ff <= accept && refuse;
      end
   end

   assign cmd_ready   = cmd_ready_ff;
   assign cmd_done    = cmd_done_ff;
   assign cmd_refused = cmd_refused_ff;
   assign status      = '{synced: synced_ff, referenced: referenced_ff,
                          holding: holding_ff, fault: fault_ff};
   assign bus_out     = 1'b0;
   assign bus_oe      = bus_oe_ff;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   property p_idle_released;
      (st_ff == ST_IDLE) || (st_ff == ST_HOLD) |-> !bus_oe_ff;
   endproperty
   a_idle_released: assert property (p_idle_released) else $error("bus driven while idle");

   property p_start_low;
      go |=> bus_oe_ff && (st_ff == ST_SEND) && (bit_idx_ff == 5'h0);
   endproperty
   a_start_low: assert property (p_start_low) else $error("frame without start bit");

   property p_bit_stable;
      (st_ff == ST_SEND) && !bit_tick |=> $stable(bus_oe_ff) || (st_ff == ST_SEND && $past(load));
   endproperty
   a_bit_stable: assert property (p_bit_stable) else $error("bus level moved mid bit");

   property p_odd_parity;
      (st_ff == ST_SEND) && (bit_idx_ff == 5'h0) |-> (^frame_ff[9:1]) && (^frame_ff[20:12]);
   endproperty
   a_odd_parity: assert property (p_odd_parity) else $error("parity not odd");

   property p_upper_first;
      go |=> (frame_ff[8:1] == hi_byte) && (frame_ff[19:12] == lo_byte);
   endproperty
   a_upper_first: assert property (p_upper_first) else $error("byte order wrong");

   property p_ref_fields;
      (cmd_ff.kind == CMD_REF) && (st_ff == ST_SEND)
         |-> (lo_byte == REF_LOW_BYTE) && (hi_byte[5:4] == MODE_NORMAL);
   endproperty
   a_ref_fields: assert property (p_ref_fields) else $error("bad reference command");

   property p_pos_map;
      (src_cmd.kind == CMD_POS) |-> (lo_byte[7] == src_cmd.position[0])
         && (hi_byte[6] == src_cmd.position[9]) && (hi_byte[7] == src_cmd.position[8]);
   endproperty
   a_pos_map: assert property (p_pos_map) else $error("position bits misplaced");

   property p_max_target;
      accept && (cmd.kind == CMD_POS) && (cmd.position > MAX_POSITION)
         |=> cmd_refused_ff && (st_ff == ST_IDLE);
   endproperty
   a_max_target: assert property (p_max_target) else $error("target above limit sent");

   property p_sync_count;
      finish && (cmd_ff.kind == CMD_SYNC) |-> (frames_sent_ff >= SYNC_REPEAT_MIN);
   endproperty
   a_sync_count: assert property (p_sync_count) else $error("too few sync frames");

   property p_pause_quiet;
      $rose(st_ff == ST_PAUSE) |-> !bus_oe_ff [*8];
   endproperty
   a_pause_quiet: assert property (p_pause_quiet) else $error("no pause after frame");

   property p_hold_blocks;
      (st_ff == ST_HOLD) |-> !cmd_ready_ff;
   endproperty
   a_hold_blocks: assert property (p_hold_blocks) else $error("accepting during ref wait");

endmodule

/* stepper_bus_device_model.sv */
`timescale 1ns/10ps
// ****************************************************************
// far-side driver model: pull-up, error clamp, frame receiver
// ****************************************************************
module stepper_bus_device_model #(
   parameter int unsigned BIT_TICKS = 8
) (
   input  wire logic  clock,
   input  wire logic  rst_b,
   input  wire logic  ctrl_oe,
   input  wire logic  clamp,
   output logic       bus_level,
   output logic [7:0] hi_ff,
   output logic [7:0] lo_ff,
   output logic       ok_ff,
   output logic [7:0] frames_ff
);
   logic        busy_ff;
   logic [15:0] tick_ff;
   logic [4:0]  idx_ff;
   logic [20:0] sh_ff;
   logic        last_ff;

   // released means pulled high; clamp beats the controller
   assign bus_level = !(ctrl_oe || clamp);

   // idle level is high, so no false edge right after reset
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) last_ff <= 1'b1;
      else last_ff <= bus_level;
   end

   // mid-bit sampling, re-centred on every level change inside a frame
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busy_ff <= 1'b0;
         tick_ff <= '0;
         idx_ff <= '0;
         sh_ff <= '0;
         hi_ff <= '0;
         lo_ff <= '0;
         ok_ff <= 1'b0;
         frames_ff <= '0;
      end else if (!busy_ff) begin
         if (!bus_level) begin
            busy_ff <= 1'b1;
            tick_ff <= 16'(BIT_TICKS / 2);
            idx_ff <= '0;
         end
      end else if ((tick_ff != 16'h0000) && (bus_level != last_ff)) begin
         // a drifting sender is pulled back to mid-bit at each edge
         tick_ff <= 16'(BIT_TICKS / 2);
      end else if (tick_ff != 16'h0000) begin
         tick_ff <= tick_ff - 16'h0001;
      end else begin
         tick_ff <= 16'(BIT_TICKS - 1);
         idx_ff <= idx_ff + 5'h01;
         if (idx_ff == 5'h15) begin
            busy_ff <= 1'b0;
            frames_ff <= frames_ff + 8'h01;
            hi_ff <= sh_ff[8:1];
            lo_ff <= sh_ff[19:12];
            // whole command rejected if any framing or parity part is off
            ok_ff <= !sh_ff[0] && sh_ff[10] && !sh_ff[11] && bus_level
                     && (^sh_ff[9:1]) && (^sh_ff[20:12]);
         end else begin
            sh_ff[idx_ff] <= bus_level;
         end
      end
   end
endmodule

/* test_stepper_bus_controller.sv */
`timescale 1ns/10ps
module test_stepper_bus_controller import stepper_bus_pkg::*;;
   localparam int unsigned BT = 8;
   localparam int unsigned RT = 50;

   logic         clock;
   logic         rst_b;
   logic         cmd_valid;
   cmd_s         cmd;
   logic         cmd_ready;
   logic         cmd_done;
   logic         cmd_refused;
   logic         fault_clr;
   link_status_s status;
   logic         bus_in;
   logic         bus_out;
   logic         bus_oe;
   logic         clamp;
   logic [7:0]   hi;
   logic [7:0]   lo;
   logic         ok;
   logic [7:0]   frames;
   int           fails;
   int           tests_run;

   stepper_bus_controller #(.BIT_TICKS(BT), .REF_TICKS(RT), .SYNC_FRAMES(4'h4)) dut (
      .clock(clock), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd(cmd),
      .cmd_ready(cmd_ready), .cmd_done(cmd_done), .cmd_refused(cmd_refused),
      .fault_clr(fault_clr), .status(status), .bus_in(bus_in), .bus_out(bus_out),
      .bus_oe(bus_oe));

   stepper_bus_device_model #(.BIT_TICKS(BT)) device (
      .clock(clock), .rst_b(rst_b), .ctrl_oe(bus_oe), .clamp(clamp), .bus_level(bus_in),
      .hi_ff(hi), .lo_ff(lo), .ok_ff(ok), .frames_ff(frames));

   always #12.5 clock = ~clock;

   // ****************************************************************
   // helpers
   // ****************************************************************
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // one request; expected bytes built from the field layout
   task automatic send(input cmd_kind_e k, input logic r, input logic t, input logic [9:0] p,
                       input logic refuse, input logic [7:0] nfr);
      int         n;
      logic [7:0] f0;
      logic [7:0] eh;
      logic [7:0] el;
      f0 = frames;
      eh = {p[8], p[9], t ? MODE_TEST : MODE_NORMAL, r ? ID_RETRACT : ID_EXTEND};
      el = {<<{p[7:0]}};
      if (k == CMD_REF) begin
         el = REF_LOW_BYTE;
      end
      if (k == CMD_SYNC) begin
         eh = SYNC_BYTE;
         el = SYNC_BYTE;
      end
      n = 0;
      cmd_valid <= 1'b1;
      cmd <= '{kind: k, retract: r, test_mode: t, position: p};
      do begin
         @(posedge clock);
         n++;
      end while (cmd_ready !== 1'b1 && n < 5000);
      if (n >= 5000) begin
         fails++;
         test_done;
      end
      cmd_valid <= 1'b0;
      @(posedge clock);
      check("refused pulse", {7'h0, cmd_refused}, {7'h0, refuse});
      n = 0;
      while (!refuse && cmd_done !== 1'b1 && n < 5000) begin
         @(posedge clock);
         n++;
      end
      if (n >= 5000) begin
         fails++;
         test_done;
      end
      repeat (2) @(posedge clock);
      if (k == CMD_REF && !refuse) begin
         check("holding", {7'h0, status.holding}, 8'h01);
         check("ready while holding", {7'h0, cmd_ready}, 8'h00);
      end
      if (refuse) begin
         repeat (3 * BT) @(posedge clock);
      end
      check("frame count", frames - f0, nfr);
      if (!refuse) begin
         check("high byte", hi, eh);
         check("low byte", lo, el);
         check("frame ok", {7'h0, ok}, 8'h01);
      end
   endtask

   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      clock = 1'b0;
      rst_b = 1'b0;
      cmd_valid = 1'b0;
      cmd = '0;
      fault_clr = 1'b0;
      clamp = 1'b0;
      fails = 0;
      tests_run = 0;
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      check("status after reset", {4'h0, status}, 8'h00);
      check("pin after reset", {6'h0, bus_out, bus_oe}, 8'h00);
      send(CMD_POS, 1'b0, 1'b0, 10'h005, 1'b1, 8'h00);
      send(CMD_REF, 1'b0, 1'b0, 10'h000, 1'b1, 8'h00);
      send(CMD_SYNC, 1'b0, 1'b0, 10'h000, 1'b0, 8'h04);
      check("synced", {7'h0, status.synced}, 8'h01);
      send(CMD_POS, 1'b0, 1'b0, 10'h005, 1'b1, 8'h00);
      send(CMD_REF, 1'b0, 1'b0, 10'h000, 1'b0, 8'h03);
      check("referenced", {7'h0, status.referenced}, 8'h01);
      send(CMD_POS, 1'b0, 1'b0, 10'h2b5, 1'b0, 8'h01);
      send(CMD_POS, 1'b0, 1'b1, 10'h13c, 1'b0, 8'h01);
      send(CMD_POS, 1'b0, 1'b0, MAX_POSITION, 1'b0, 8'h01);
      send(CMD_POS, 1'b0, 1'b0, MAX_POSITION + 10'h001, 1'b1, 8'h00);
      send(CMD_POS, 1'b1, 1'b0, 10'h010, 1'b1, 8'h00);
      send(CMD_REF, 1'b1, 1'b0, 10'h000, 1'b1, 8'h00);
      send(CMD_REF, 1'b0, 1'b0, 10'h000, 1'b0, 8'h01);
      // error clamp from the far side while the controller is silent
      clamp <= 1'b1;
      repeat (BT + 4) @(posedge clock);
      clamp <= 1'b0;
      repeat (3) @(posedge clock);
      check("fault set", {7'h0, status.fault}, 8'h01);
      fault_clr <= 1'b1;
      @(posedge clock);
      fault_clr <= 1'b0;
      repeat (2) @(posedge clock);
      check("fault cleared", {7'h0, status.fault}, 8'h00);
      test_done;
   end

   // far above the few thousand cycles the sequence needs
   initial begin
      #(20000 * 25);
      fails++;
      $display("watchdog expired");
      test_done;
   end
endmodule
